// ### rtl/sacc_checker.sv
// Sector access condition checker with its 1 kB sector memory
`timescale 1ns/1ps
`include "sacc_params.svh"


module sacc_checker
	import sacc_pkg::*;
#(
	parameter logic [127:0] UID_BLOCK = `SACC_UID_DEFAULT // Arbitrary value
)
(
	input  wire logic         CLOCK_I,
	input  wire logic         RST_I,
	input  wire logic         SELECTED_I,
	input  wire logic         AUTH_VALID_I,
	input  wire logic [7:0]   AUTH_CMD_I,
	input  wire logic [7:0]   AUTH_ADDR_I,
	input  wire logic         REQ_VALID_I,
	input  wire logic [2:0]   REQ_OP_I,
	input  wire logic [7:0]   REQ_ADDR_I,
	input  wire logic [127:0] REQ_WDATA_I,
	input  wire logic [31:0]  REQ_OPERAND_I,
	output logic              RSP_VALID_O,
	output logic              RSP_ACK_O,
	output logic [127:0]      RSP_DATA_O,
	output logic [31:0]       VALUE_O,
	output logic              VALUE_VALID_O,
	output logic              AUTH_OK_O,
	output logic              SESSION_DEAD_O,
	output logic [15:0]       SECTOR_LOCKED_O
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Encode a trailer code and one shared data code into trailer bytes 6 to 8
	function automatic logic [23:0] enc_acc(input logic [2:0] trl,
		input logic [2:0] dat);
		logic [3:0] one;
		logic [3:0] two;
		logic [3:0] three;
		one   = {trl[2], {3{dat[2]}}};
		two   = {trl[1], {3{dat[1]}}};
		three = {trl[0], {3{dat[0]}}};
		return {three, two, one, ~three, ~two, ~one};
	endfunction : enc_acc

	// Delivery image: transport trailers, blank data, manufacturer block
	function automatic logic [63:0][127:0] delivery_image();
		logic [63:0][127:0] img;
		img = '0;
		for (int s = 0; s < 16; s++)
		begin
			img[s*4+3] = {`SACC_KEY_DELIVERY, `SACC_USER9_DELIVERY,
				enc_acc(`SACC_CODE_TRANSPORT_TRL,
				`SACC_CODE_TRANSPORT_DAT),
				`SACC_KEY_DELIVERY};
		end
		img[`SACC_MFR_ADDR] = UID_BLOCK;
		return img;
	endfunction : delivery_image

	// Trailer rights: {A write, AB read, AB write, B read, B write}
	function automatic logic [9:0] trl_perm(input logic [2:0] code);
		unique case (code)
			3'h0: trl_perm = {2'h1, 2'h1, 2'h0, 2'h1, 2'h1};
			3'h2: trl_perm = {2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
			3'h4: trl_perm = {2'h2, 2'h3, 2'h0, 2'h0, 2'h2};
			3'h6: trl_perm = {2'h0, 2'h3, 2'h0, 2'h0, 2'h0};
			3'h1: trl_perm = {2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
			3'h3: trl_perm = {2'h2, 2'h3, 2'h2, 2'h0, 2'h2};
			3'h5: trl_perm = {2'h0, 2'h3, 2'h2, 2'h0, 2'h0};
			3'h7: trl_perm = {2'h0, 2'h3, 2'h0, 2'h0, 2'h0};
		endcase
	endfunction : trl_perm

	// Data rights: {read, write, increment, decrement/transfer/restore}
	function automatic logic [7:0] dat_perm(input logic [2:0] code);
		unique case (code)
			3'h0: dat_perm = {2'h3, 2'h3, 2'h3, 2'h3};
			3'h2: dat_perm = {2'h3, 2'h0, 2'h0, 2'h0};
			3'h4: dat_perm = {2'h3, 2'h2, 2'h0, 2'h0};
			3'h6: dat_perm = {2'h3, 2'h2, 2'h2, 2'h3};
			3'h1: dat_perm = {2'h3, 2'h0, 2'h0, 2'h3};
			3'h3: dat_perm = {2'h2, 2'h2, 2'h0, 2'h0};
			3'h5: dat_perm = {2'h2, 2'h0, 2'h0, 2'h0};
			3'h7: dat_perm = {2'h0, 2'h0, 2'h0, 2'h0};
		endcase
	endfunction : dat_perm

	// Right granted to the authenticated key
	function automatic logic may(input logic [1:0] p, input logic second);
		return second ? p[1] : p[0];
	endfunction : may

	// Redundant value block format check
	function automatic logic is_value(input logic [127:0] b);
		logic [31:0] v;
		logic [7:0]  a;
		v = b[`SACC_VAL0_LSB +: 32];
		a = b[`SACC_ADR0_LSB +: 8];
		return (b[`SACC_VALN_LSB +: 32] == ~v) &&
		       (b[`SACC_VAL1_LSB +: 32] == v) &&
		       (b[`SACC_ADRN0_LSB +: 8] == ~a) &&
		       (b[`SACC_ADR1_LSB +: 8] == a) &&
		       (b[`SACC_ADRN1_LSB +: 8] == ~a);
	endfunction : is_value

	// ****************************************************************
	// State and trailer decode of the addressed sector
	// ****************************************************************
	sacc_state_t st;
	sacc_state_t next_st;
	logic [7:0]  sel_addr;
	logic [3:0]  sel_sector;
	logic [127:0] sel_trailer;
	logic [11:0] codes;
	logic        fmt_ok;

	// Auth takes priority over a request for the trailer lookup
	assign sel_addr    = AUTH_VALID_I ? AUTH_ADDR_I : REQ_ADDR_I;
	assign sel_sector  = sel_addr[5:2];
	assign sel_trailer = st.mem[{sel_sector, `SACC_TRAILER_BLK}];

	sacc_trailer_decode u_decode
	(
		.acc_bytes_i (sel_trailer[`SACC_ACC_LSB +: 24]),
		.codes_o     (codes),
		.format_ok_o (fmt_ok)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic [9:0]   tp;
		logic [7:0]   dp;
		logic [1:0]   blk;
		logic [5:0]   idx;
		logic [127:0] cur;
		logic         keyb_rd;
		logic         cred;
		logic         ok;
		logic         mfr;
		logic [31:0]  val;
		logic [127:0] wr;
		tp      = trl_perm(codes[9 +: 3]);
		blk     = sel_addr[1:0];
		idx     = sel_addr[5:0];
		dp      = dat_perm(codes[blk*3 +: 3]);
		cur     = st.mem[idx];
		keyb_rd = (tp[3:2] != `SACC_P_NEVER);
		cred    = !(st.auth_second && keyb_rd);
		val     = cur[`SACC_VAL0_LSB +: 32];
		mfr     = (idx == `SACC_MFR_ADDR);
		wr      = cur;
		ok      = 1'b0;
		next_st           = st;
		next_st.rsp_valid = 1'b0;
		next_st.rsp_ack   = 1'b0;
		// Leaving the selected state ends the session
		if (!SELECTED_I)
		begin
			next_st.auth_ok      = 1'b0;
			next_st.session_dead = 1'b0;
			next_st.value_valid  = 1'b0;
		end
		if (SELECTED_I && AUTH_VALID_I)
		begin
			next_st.auth_ok      = 1'b0;
			next_st.session_dead = 1'b0;
			if (!fmt_ok)
				next_st.locked[sel_sector] = 1'b1;
			else if (sel_addr[7:6] == 2'h0 && !st.locked[sel_sector] &&
				(AUTH_CMD_I == `SACC_CMD_AUTH_FIRST ||
				AUTH_CMD_I == `SACC_CMD_AUTH_SECOND))
			begin
				next_st.auth_ok     = 1'b1;
				next_st.auth_sector = sel_sector;
				next_st.auth_second = (AUTH_CMD_I == `SACC_CMD_AUTH_SECOND);
				next_st.session_dead = (AUTH_CMD_I == `SACC_CMD_AUTH_SECOND)
					&& keyb_rd;
			end
		end
		else if (REQ_VALID_I && !AUTH_VALID_I)
		begin
			next_st.rsp_valid = 1'b1;
			next_st.rsp_data  = '0;
			if (!fmt_ok)
				next_st.locked[sel_sector] = 1'b1;
			if (SELECTED_I && st.auth_ok && !st.session_dead && cred &&
				sel_addr[7:6] == 2'h0 && st.auth_sector == sel_sector &&
				fmt_ok && !st.locked[sel_sector])
			begin
				if (blk == `SACC_TRAILER_BLK)
				begin
					// Trailer: per-field rights, value ops never
					unique case (REQ_OP_I)
						SACC_OP_READ:
						begin
							ok = may(tp[7:6], st.auth_second);
							next_st.rsp_data[`SACC_ACC_LSB +: 32] =
								cur[`SACC_ACC_LSB +: 32];
							if (may(tp[3:2], st.auth_second))
								next_st.rsp_data[`SACC_KEYB_LSB +: 48] =
									cur[`SACC_KEYB_LSB +: 48];
							if (!ok)
								next_st.rsp_data = '0;
						end
						SACC_OP_WRITE:
						begin
							if (may(tp[9:8], st.auth_second))
								wr[`SACC_KEYA_LSB +: 48] =
									REQ_WDATA_I[`SACC_KEYA_LSB +: 48];
							if (may(tp[5:4], st.auth_second))
								wr[`SACC_ACC_LSB +: 32] =
									REQ_WDATA_I[`SACC_ACC_LSB +: 32];
							if (may(tp[1:0], st.auth_second))
								wr[`SACC_KEYB_LSB +: 48] =
									REQ_WDATA_I[`SACC_KEYB_LSB +: 48];
							ok = may(tp[9:8], st.auth_second) ||
								may(tp[5:4], st.auth_second) ||
								may(tp[1:0], st.auth_second);
						end
						default: ok = 1'b0;
					endcase
				end
				else
				begin
					unique case (REQ_OP_I)
						SACC_OP_READ:
						begin
							ok = may(dp[7:6], st.auth_second);
							if (ok)
								next_st.rsp_data = cur;
						end
						SACC_OP_WRITE:
						begin
							ok = may(dp[5:4], st.auth_second) && !mfr;
							wr = REQ_WDATA_I;
						end
						SACC_OP_INCR:
						begin
							ok = may(dp[3:2], st.auth_second) && is_value(cur)
								&& !mfr;
							next_st.value_reg = val + REQ_OPERAND_I;
						end
						SACC_OP_DECR:
						begin
							ok = may(dp[1:0], st.auth_second) && is_value(cur)
								&& !mfr;
							next_st.value_reg = val - REQ_OPERAND_I;
						end
						SACC_OP_RESTORE:
						begin
							ok = may(dp[1:0], st.auth_second) && is_value(cur)
								&& !mfr;
							next_st.value_reg = val;
						end
						SACC_OP_TRANSFER:
						begin
							ok = may(dp[1:0], st.auth_second) && is_value(cur)
								&& st.value_valid && !mfr;
							wr[`SACC_VAL0_LSB +: 32] = st.value_reg;
							wr[`SACC_VALN_LSB +: 32] = ~st.value_reg;
							wr[`SACC_VAL1_LSB +: 32] = st.value_reg;
						end
						default: ok = 1'b0;
					endcase
				end
			end

			// Commit only granted effects
			next_st.rsp_ack = ok;
			if (!ok)
				next_st.value_reg = st.value_reg;
			else if (REQ_OP_I == SACC_OP_INCR || REQ_OP_I == SACC_OP_DECR ||
				REQ_OP_I == SACC_OP_RESTORE)
				next_st.value_valid = 1'b1;
			if (ok && (REQ_OP_I == SACC_OP_WRITE ||
				REQ_OP_I == SACC_OP_TRANSFER))
				next_st.mem[idx] = wr;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			st        <= '0;
			st.mem    <= delivery_image();
		end
		else
			st <= next_st;
	end

	// Outputs straight from the state register
	assign RSP_VALID_O     = st.rsp_valid;
	assign RSP_ACK_O       = st.rsp_ack;
	assign RSP_DATA_O      = st.rsp_data;
	assign VALUE_O         = st.value_reg;
	assign VALUE_VALID_O   = st.value_valid;
	assign AUTH_OK_O       = st.auth_ok;
	assign SESSION_DEAD_O  = st.session_dead;
	assign SECTOR_LOCKED_O = st.locked;

endmodule : sacc_checker

// ### rtl/sacc_params.svh
// Constants of the sector access condition checker
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH

// ****************************************************************
// Memory geometry
// ****************************************************************
`define SACC_NUM_BLOCKS      64
`define SACC_TRAILER_BLK     2'h3
`define SACC_MFR_ADDR        6'h00

// ****************************************************************
// Field positions inside a block (bit offsets, byte n at 8*n)
// ****************************************************************
`define SACC_KEYA_LSB        0
`define SACC_ACC_LSB         48
`define SACC_USER9_LSB       72
`define SACC_KEYB_LSB        80
`define SACC_VAL0_LSB        0
`define SACC_VALN_LSB        32
`define SACC_VAL1_LSB        64
`define SACC_ADR0_LSB        96
`define SACC_ADRN0_LSB       104
`define SACC_ADR1_LSB        112
`define SACC_ADRN1_LSB       120

// ****************************************************************
// Reset and delivery values
// ****************************************************************
`define SACC_KEY_DELIVERY    48'hffffffffffff
`define SACC_CODE_TRANSPORT_TRL 3'h1
`define SACC_CODE_TRANSPORT_DAT 3'h0
`define SACC_USER9_DELIVERY  8'h00
`define SACC_UID_DEFAULT     128'h0123456789abcdef0123456789abcdef

// ****************************************************************
// Authentication command bytes
// ****************************************************************
`define SACC_CMD_AUTH_FIRST  8'h60
`define SACC_CMD_AUTH_SECOND 8'h61

// ****************************************************************
// Permission codes (bit 0 first key, bit 1 second key)
// ****************************************************************
`define SACC_P_NEVER         2'h0
`define SACC_P_FIRST         2'h1
`define SACC_P_SECOND        2'h2
`define SACC_P_EITHER        2'h3

`endif

// ### rtl/sacc_pkg.sv
// Types of the sector access condition checker
package sacc_pkg;

	// Memory operations requested by the reader side
	typedef enum logic [2:0]
	{
		SACC_OP_READ     = 3'h0,
		SACC_OP_WRITE    = 3'h1,
		SACC_OP_INCR     = 3'h2,
		SACC_OP_DECR     = 3'h3,
		SACC_OP_RESTORE  = 3'h4,
		SACC_OP_TRANSFER = 3'h5
	} sacc_op_t;

	// Complete state of the checker
	typedef struct packed
	{
		logic [63:0][127:0] mem;
		logic [15:0]        locked;
		logic               auth_ok;
		logic               auth_second;
		logic [3:0]         auth_sector;
		logic               session_dead;
		logic [31:0]        value_reg;
		logic               value_valid;
		logic               rsp_valid;
		logic               rsp_ack;
		logic [127:0]       rsp_data;
	} sacc_state_t;

endpackage : sacc_pkg

// ### rtl/sacc_trailer_decode.sv
// Access byte decoder and format check for one sector trailer
`timescale 1ns/1ps

module sacc_trailer_decode
	import sacc_pkg::*;
(
	input  wire logic [23:0] acc_bytes_i,
	output logic [11:0]      codes_o,
	output logic             format_ok_o
);

	logic [3:0] bit_one;
	logic [3:0] bit_two;
	logic [3:0] bit_three;

	// ****************************************************************
	// Split bytes 6 to 8 into true and inverted access bits
	// ****************************************************************
	always_comb
	begin
		bit_one   = acc_bytes_i[15:12];
		bit_two   = acc_bytes_i[19:16];
		bit_three = acc_bytes_i[23:20];
		// Every true bit must be the complement of its copy
		format_ok_o = (acc_bytes_i[3:0]  == ~bit_one) &&
		              (acc_bytes_i[7:4]  == ~bit_two) &&
		              (acc_bytes_i[11:8] == ~bit_three);
		for (int b = 0; b < 4; b++)
		begin
			codes_o[b*3 +: 3] = {bit_one[b], bit_two[b], bit_three[b]};
		end
	end

endmodule : sacc_trailer_decode

// ### tb/sacc_checker_asserts.sv
// Concurrent checks on the ports of the sector access condition checker
`timescale 1ns/1ps

module sacc_checker_asserts
	import sacc_pkg::*;
(
	input logic         CLOCK_I,
	input logic         RST_I,
	input logic         SELECTED_I,
	input logic         AUTH_VALID_I,
	input logic [7:0]   AUTH_CMD_I,
	input logic [7:0]   AUTH_ADDR_I,
	input logic         REQ_VALID_I,
	input logic [2:0]   REQ_OP_I,
	input logic [7:0]   REQ_ADDR_I,
	input logic [127:0] REQ_WDATA_I,
	input logic [31:0]  REQ_OPERAND_I,
	input logic         RSP_VALID_O,
	input logic         RSP_ACK_O,
	input logic [127:0] RSP_DATA_O,
	input logic [31:0]  VALUE_O,
	input logic         VALUE_VALID_O,
	input logic         AUTH_OK_O,
	input logic         SESSION_DEAD_O,
	input logic [15:0]  SECTOR_LOCKED_O
);
	logic tk;

	// Memory request taken at this edge
	assign tk = REQ_VALID_I && !AUTH_VALID_I;

	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	// ****************
	// Request answers, session and lock rules
	// ****************
	a_rsp_next: assert property (tk |=> RSP_VALID_O)
		else $error("request without response");
	a_unsel_refuse: assert property (tk && !SELECTED_I |=> !RSP_ACK_O)
		else $error("grant while unselected");
	a_unauth_refuse: assert property (tk && !AUTH_OK_O |=> !RSP_ACK_O)
		else $error("grant without authentication");
	a_desel_ends: assert property (!SELECTED_I |=> !AUTH_OK_O)
		else $error("session survives deselect");
	a_dead_refuse: assert property (tk && SESSION_DEAD_O |=> !RSP_ACK_O)
		else $error("grant in dead session");
	a_lock_refuse: assert property
		(tk && SECTOR_LOCKED_O[REQ_ADDR_I[5:2]] |=> !RSP_ACK_O)
		else $error("grant in locked sector");
	a_lock_sticky: assert property
		(!$past(RST_I) |-> (SECTOR_LOCKED_O & $past(SECTOR_LOCKED_O))
			== $past(SECTOR_LOCKED_O))
		else $error("sector lock released");
	a_mfr_ro: assert property
		(tk && REQ_OP_I == SACC_OP_WRITE && REQ_ADDR_I == 8'h00 |=> !RSP_ACK_O)
		else $error("manufacturer block written");
	a_first_key_zero: assert property
		(tk && REQ_OP_I == SACC_OP_READ && REQ_ADDR_I[1:0] == 2'h3
			|=> RSP_DATA_O[47:0] == 48'h0)
		else $error("first key visible");
	a_value_cause: assert property
		($rose(VALUE_VALID_O) |-> RSP_ACK_O && $past(REQ_OP_I) inside
			{SACC_OP_INCR, SACC_OP_DECR, SACC_OP_RESTORE})
		else $error("value register loaded without value op");
	a_auth_cmd: assert property
		(AUTH_VALID_I && !(AUTH_CMD_I inside {8'h60, 8'h61}) |=> !AUTH_OK_O)
		else $error("auth with unknown command");
endmodule : sacc_checker_asserts

bind sacc_checker sacc_checker_asserts u_chk (.CLOCK_I, .RST_I, .SELECTED_I,
	.AUTH_VALID_I, .AUTH_CMD_I, .AUTH_ADDR_I, .REQ_VALID_I, .REQ_OP_I,
	.REQ_ADDR_I, .REQ_WDATA_I, .REQ_OPERAND_I, .RSP_VALID_O, .RSP_ACK_O,
	.RSP_DATA_O, .VALUE_O, .VALUE_VALID_O, .AUTH_OK_O, .SESSION_DEAD_O,
	.SECTOR_LOCKED_O);

// ### tb/sacc_reader_model.sv
// Reader model issuing selections, authentications and memory requests
`timescale 1ns/1ps

module sacc_reader_model
(
	input  wire logic    clk_i,
	output logic         sel_o,
	output logic         auth_v_o,
	output logic [7:0]   auth_cmd_o,
	output logic [7:0]   auth_adr_o,
	output logic         req_v_o,
	output logic [2:0]   req_op_o,
	output logic [7:0]   req_adr_o,
	output logic [127:0] req_wd_o,
	output logic [31:0]  req_opd_o
);
	// Idle at time zero
	initial {sel_o, auth_v_o, auth_cmd_o, auth_adr_o, req_v_o, req_op_o,
		req_adr_o, req_wd_o, req_opd_o} = '0;

	// Select level; low ends the session
	task sel(input logic v);
		@(negedge clk_i);
		sel_o = v;
	endtask : sel

	// One auth pulse; caller picks key byte, first key on transport sectors
	task auth(input logic [7:0] c, input logic [7:0] a);
		@(negedge clk_i);
		{auth_v_o, auth_cmd_o, auth_adr_o} = {1'h1, c, a};
		@(negedge clk_i);
		auth_v_o = 1'h0;
		auth_cmd_o = ~c; // Released command line shows no stale value
	endtask : auth

	// One request; value blocks are always sent whole in value format
	task req(input logic [2:0] o, input logic [7:0] a,
		input logic [127:0] w, input logic [31:0] d);
		@(negedge clk_i);
		{req_v_o, req_op_o, req_adr_o, req_wd_o, req_opd_o} = {1'h1, o, a, w, d};
		@(negedge clk_i);
		req_v_o = 1'h0;
		req_wd_o = ~w;
		req_opd_o = ~d;
	endtask : req
endmodule : sacc_reader_model

// ### tb/testbench.sv
// Self-checking bench of the sector access condition checker
`timescale 1ns/1ps

module testbench
	import sacc_pkg::*;
;
	// Arbitrary manufacturer block contents
	localparam logic [127:0] UNIQUE_IDENTIFIER = 128'h5a5a0f0f3c3c9696a5a5f0f0c3c36969;
	logic         clk = 1'h0;
	logic         rst = 1'h1;
	logic         sel, av, rv, rsp_v, ack, vv, aok, dead;
	logic [7:0]   acmd, aadr, radr;
	logic [2:0]   rop;
	logic [31:0]  ropd, val;
	logic [127:0] rwd, rdat;
	logic [15:0]  lock;
	int           failures = 0;
	int           total_checks = 0;
	int           cyc = 0;

	// Free-running clock
	always #4 clk = ~clk;

	sacc_checker #(.UID_BLOCK(UNIQUE_IDENTIFIER)) u_dut
	(
		.CLOCK_I         (clk),
		.RST_I           (rst),
		.SELECTED_I      (sel),
		.AUTH_VALID_I    (av),
		.AUTH_CMD_I      (acmd),
		.AUTH_ADDR_I     (aadr),
		.REQ_VALID_I     (rv),
		.REQ_OP_I        (rop),
		.REQ_ADDR_I      (radr),
		.REQ_WDATA_I     (rwd),
		.REQ_OPERAND_I   (ropd),
		.RSP_VALID_O     (rsp_v),
		.RSP_ACK_O       (ack),
		.RSP_DATA_O      (rdat),
		.VALUE_O         (val),
		.VALUE_VALID_O   (vv),
		.AUTH_OK_O       (aok),
		.SESSION_DEAD_O  (dead),
		.SECTOR_LOCKED_O (lock)
	);

	sacc_reader_model u_rdr
	(
		.clk_i      (clk),
		.sel_o      (sel),
		.auth_v_o   (av),
		.auth_cmd_o (acmd),
		.auth_adr_o (aadr),
		.req_v_o    (rv),
		.req_op_o   (rop),
		.req_adr_o  (radr),
		.req_wd_o   (rwd),
		.req_opd_o  (ropd)
	);

	// Compare and count
	task chk(input logic [127:0] s, input logic [127:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// Request followed by a check of its answer
	task op(input logic [2:0] o, input logic [7:0] a, input logic [127:0] w,
		input logic [31:0] d, input logic k);
		u_rdr.req(o, a, w, d);
		chk({rsp_v, ack}, {1'h1, k});
	endtask : op

	// Value block image: value three times, address four times
	function automatic logic [127:0] vb(input logic [31:0] v,
		input logic [7:0] a);
		return {~a, a, ~a, a, v, ~v, v};
	endfunction : vb

	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// Cycle ceiling against a hung run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			results();
		end
	end

	// Main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'h0;
		op(SACC_OP_READ, 8'h05, '0, '0, 1'h0);
		u_rdr.sel(1'h1);
		op(SACC_OP_READ, 8'h05, '0, '0, 1'h0);
		u_rdr.auth(8'h30, 8'h04);
		chk(aok, 1'h0);
		u_rdr.auth(8'h60, 8'h04);
		chk(aok, 1'h1);
		op(SACC_OP_READ, 8'h07, '0, '0, 1'h1);
		chk(rdat, {{12{4'hf}}, 32'h008007ff, 48'h0});
		op(SACC_OP_READ, 8'h08, '0, '0, 1'h0);
		op(SACC_OP_WRITE, 8'h05, vb(32'ha, 8'h05), '0, 1'h1);
		op(SACC_OP_WRITE, 8'h06, vb(32'h0, 8'h77), '0, 1'h1);
		op(SACC_OP_WRITE, 8'h04, 128'h1, '0, 1'h1);
		op(SACC_OP_READ, 8'h05, '0, '0, 1'h1);
		chk(rdat, vb(32'ha, 8'h05));
		op(SACC_OP_INCR, 8'h05, '0, 32'h5, 1'h1);
		chk(val, 32'hf);
		chk(vv, 1'h1);
		op(SACC_OP_TRANSFER, 8'h06, '0, '0, 1'h1);
		op(SACC_OP_READ, 8'h06, '0, '0, 1'h1);
		chk(rdat, vb(32'hf, 8'h77));
		op(SACC_OP_DECR, 8'h05, '0, 32'h14, 1'h1);
		chk(val, 32'hfffffff6);
		op(SACC_OP_RESTORE, 8'h05, '0, '0, 1'h1);
		chk(val, 32'ha);
		op(SACC_OP_INCR, 8'h04, '0, 32'h5, 1'h0);
		op(SACC_OP_INCR, 8'h07, '0, 32'h5, 1'h0);
		// Block 1 non-rechargeable, block 2 closed, user byte and second key
		op(SACC_OP_WRITE, 8'h07, {48'h112233445566, 8'h5a, 24'he441bb,
			{12{4'hf}}}, '0, 1'h1);
		op(SACC_OP_READ, 8'h07, '0, '0, 1'h1);
		chk(rdat, {48'h112233445566, 8'h5a, 24'he441bb, 48'h0});
		op(SACC_OP_WRITE, 8'h05, vb(32'h1, 8'h05), '0, 1'h0);
		op(SACC_OP_INCR, 8'h05, '0, 32'h1, 1'h0);
		op(SACC_OP_DECR, 8'h05, '0, 32'h1, 1'h1);
		chk(val, 32'h9);
		op(SACC_OP_READ, 8'h06, '0, '0, 1'h0);
		chk(rdat, 128'h0);
		u_rdr.auth(8'h61, 8'h04);
		chk(dead, 1'h1);
		op(SACC_OP_READ, 8'h04, '0, '0, 1'h0);
		u_rdr.sel(1'h0);
		u_rdr.sel(1'h1);
		chk(vv, 1'h0);
		chk(aok, 1'h0);
		u_rdr.auth(8'h60, 8'h00);
		op(SACC_OP_READ, 8'h00, '0, '0, 1'h1);
		chk(rdat, UNIQUE_IDENTIFIER);
		op(SACC_OP_WRITE, 8'h00, '0, '0, 1'h0);
		op(SACC_OP_READ, 8'h00, '0, '0, 1'h1);
		chk(rdat, UNIQUE_IDENTIFIER);
		// Access bytes whose true and inverted copies disagree
		u_rdr.req(SACC_OP_WRITE, 8'h03, {56'h0, 24'h800700, {12{4'hf}}}, '0);
		op(SACC_OP_READ, 8'h01, '0, '0, 1'h0);
		chk(lock, 16'h1);
		op(SACC_OP_READ, 8'h01, '0, '0, 1'h0);
		chk(lock, 16'h1);
		results();
	end
endmodule : testbench
